// *** design/drv_own.v ***
// Purpose: Grants or releases each bus driver except bus reset according to bus phase
// Assumes: Phase and role flags come from logic on mclk
// Notes:   Every output is registered; released means oe low
`timescale 1ns/1ps
`include "drv_own_consts.vh"

// Function
// - During arbitration only the own identifier data bit may be driven.
// - During arbitration parity is either released or driven asserted.
// - During arbitration parity is never driven negated.
// - Jointly owned signals may be driven by initiator or target or both.
// - Initiator-owned signals are driven only by the active initiator.
// - Signals owned by nobody in a phase are released by every device.
// - Winner-owned signals are driven only by the arbitration winner.
// - An arbitrating device drives the data bit of its own identifier.
// - Signals owned by all arbitrators are driven while arbitrating.
// - Any driver not an active source in the phase is released.
// - Bus reset may be asserted at any time regardless of phase.
module drv_own #(
  parameter ID_W = 3,
  parameter DB_W = 8
) (
  // Clock and reset
  input  wire            mclk,
  input  wire            rst_b,
  // Phase and role
  input  wire [3:0]      phase,
  input  wire [ID_W-1:0] own_id,
  input  wire            arbitrating,
  input  wire            arb_won,
  input  wire            act_init,
  input  wire            act_targ,
  // Drive requests from protocol logic
  input  wire            bsy_req,
  input  wire            sel_req,
  input  wire [2:0]      ctrl_req,
  input  wire            req_req,
  input  wire            ack_req,
  input  wire            atn_req,
  input  wire            db_req,
  input  wire [DB_W-1:0] db_val,
  input  wire            dbp_val,
  input  wire            arb_par_drive,
  input  wire            rst_req,
  // Bus reset seen on the pin
  input  wire            bus_rst_pin,
  // Driver outputs, value and enable
  output reg             bsy_oe_r,
  output reg             sel_oe_r,
  output reg  [2:0]      ctrl_oe_r,
  output reg             req_oe_r,
  output reg             ack_oe_r,
  output reg             atn_oe_r,
  output reg  [DB_W-1:0] db_out_r,
  output reg  [DB_W-1:0] db_oe_r,
  output reg             dbp_out_r,
  output reg             dbp_oe_r,
  output reg             rst_oe_r
);

  // ----------------------------------------------------------------
  // Bus reset synchroniser
  // ----------------------------------------------------------------
  // Pin is asynchronous to mclk; only the second stage is read
  reg brst_s1_r;
  reg brst_s2_r;

  always @(posedge mclk) begin
    if (!rst_b) begin
      brst_s1_r <= 1'b0;
      brst_s2_r <= 1'b0;
    end else begin
      brst_s1_r <= bus_rst_pin;
      brst_s2_r <= brst_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Ownership table
  // ----------------------------------------------------------------
  reg [2:0] src_bsy;
  reg [2:0] src_sel;
  reg [2:0] src_ctrl;
  reg [2:0] src_ackatn;
  reg [2:0] src_db;

  // Unlisted phase codes leave every class at none
  always @* begin
    src_bsy    = `SRC_NONE;
    src_sel    = `SRC_NONE;
    src_ctrl   = `SRC_NONE;
    src_ackatn = `SRC_NONE;
    src_db     = `SRC_NONE;
    case (phase)
      `PH_ARB: begin
        src_bsy = `SRC_ALL;
        src_sel = `SRC_WIN;
        src_db  = `SRC_SID;
      end
      `PH_SEL: begin
        src_bsy    = `SRC_IT;
        src_sel    = `SRC_INIT;
        src_ackatn = `SRC_INIT;
        src_db     = `SRC_INIT;
      end
      `PH_RESEL: begin
        src_bsy    = `SRC_IT;
        src_sel    = `SRC_TARG;
        src_ctrl   = `SRC_TARG;
        src_ackatn = `SRC_INIT;
        src_db     = `SRC_TARG;
      end
      `PH_CMD, `PH_DOUT, `PH_MOUT: begin
        src_bsy    = `SRC_TARG;
        src_ctrl   = `SRC_TARG;
        src_ackatn = `SRC_INIT;
        src_db     = `SRC_INIT;
      end
      `PH_DIN, `PH_STAT, `PH_MIN: begin
        src_bsy    = `SRC_TARG;
        src_ctrl   = `SRC_TARG;
        src_ackatn = `SRC_INIT;
        src_db     = `SRC_TARG;
      end
      default: begin
        src_bsy = `SRC_NONE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Grant of a source class to this device
  // ----------------------------------------------------------------
  // Reads the role inputs directly
  function grant;
    input [2:0] src;
    begin
      case (src)
        `SRC_ALL:  grant = arbitrating;
        `SRC_WIN:  grant = arbitrating & arb_won;
        `SRC_SID:  grant = arbitrating;
        `SRC_IT:   grant = act_init | act_targ;
        `SRC_INIT: grant = act_init;
        `SRC_TARG: grant = act_targ;
        default:   grant = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Next driver state
  // ----------------------------------------------------------------
  // Phase decode and data group grant
  wire            arb_ph = (phase == `PH_ARB);
  wire            g_db   = grant(src_db);
  // One-hot data bit of the own identifier
  wire [DB_W-1:0] id_bit = {{(DB_W-1){1'b0}}, 1'b1} << own_id;

  reg [DB_W-1:0] db_out_nxt;
  reg [DB_W-1:0] db_oe_nxt;
  reg            dbp_out_nxt;
  reg            dbp_oe_nxt;

  always @* begin
    // Outside arbitration all data bits share one enable
    db_out_nxt  = db_val;
    db_oe_nxt   = {DB_W{g_db & db_req}};
    dbp_out_nxt = dbp_val;
    dbp_oe_nxt  = g_db & db_req;
    // Arbitration: own bit only, parity fixed asserted
    if (arb_ph) begin
      db_out_nxt  = id_bit;
      db_oe_nxt   = {DB_W{g_db}} & id_bit;
      dbp_out_nxt = 1'b1;
      dbp_oe_nxt  = g_db & arb_par_drive;
    end
  end

  // ----------------------------------------------------------------
  // Registered drivers; bus reset clears all but reset itself
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_b || brst_s2_r) begin
      bsy_oe_r  <= 1'b0;
      sel_oe_r  <= 1'b0;
      ctrl_oe_r <= 3'h0;
      req_oe_r  <= 1'b0;
      ack_oe_r  <= 1'b0;
      atn_oe_r  <= 1'b0;
      db_out_r  <= {DB_W{1'b0}};
      db_oe_r   <= {DB_W{1'b0}};
      dbp_out_r <= 1'b0;
      dbp_oe_r  <= 1'b0;
    end else begin
      bsy_oe_r  <= grant(src_bsy) & bsy_req;
      sel_oe_r  <= grant(src_sel) & sel_req;
      ctrl_oe_r <= {3{grant(src_ctrl)}} & ctrl_req;
      // REQ follows the control group's class
      req_oe_r  <= grant(src_ctrl) & req_req;
      ack_oe_r  <= grant(src_ackatn) & ack_req;
      atn_oe_r  <= grant(src_ackatn) & atn_req;
      db_out_r  <= db_out_nxt;
      db_oe_r   <= db_oe_nxt;
      dbp_out_r <= dbp_out_nxt;
      dbp_oe_r  <= dbp_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bus reset driver
  // ----------------------------------------------------------------
  // Not cleared by a bus reset; any device may assert it at any time
  always @(posedge mclk) begin
    if (!rst_b) begin
      rst_oe_r <= 1'b0;
    end else begin
      rst_oe_r <= rst_req;
    end
  end

endmodule // drv_own

// *** design/drv_own_consts.vh ***
// Purpose: Constants for the bus driver ownership block
// Assumes: Phase codes are produced by the local phase sequencer
// Notes:   Source codes classify who may drive a signal group
`ifndef DRV_OWN_CONSTS_VH
`define DRV_OWN_CONSTS_VH

// ----------------------------------------------------------------
// Bus phase codes
// ----------------------------------------------------------------
`define PH_FREE   4'h0
`define PH_ARB    4'h1
`define PH_SEL    4'h2
`define PH_RESEL  4'h3
`define PH_CMD    4'h4
`define PH_DIN    4'h5
`define PH_DOUT   4'h6
`define PH_STAT   4'h7
`define PH_MIN    4'h8
`define PH_MOUT   4'h9

// ----------------------------------------------------------------
// Signal source classes
// ----------------------------------------------------------------
`define SRC_NONE  3'h0
`define SRC_ALL   3'h1
`define SRC_WIN   3'h2
`define SRC_SID   3'h3
`define SRC_IT    3'h4
`define SRC_INIT  3'h5
`define SRC_TARG  3'h6

`endif

// *** dv/drv_own_assertions.sv ***
// Purpose: Ownership checks on driver enables
// Assumes: Outputs lag inputs by one mclk
// Notes:   Checks other than the bus reset release pause while bus reset is near
`timescale 1ns/1ps
`include "drv_own_consts.vh"
module drv_own_assertions #(parameter ID_W = 3, parameter DB_W = 8) (
  input wire mclk, rst_b, arbitrating, arb_won, act_init, act_targ,
  input wire bsy_req, sel_req, arb_par_drive, rst_req, bus_rst_pin,
  input wire [3:0] phase,
  input wire [ID_W-1:0] own_id,
  input wire bsy_oe_r, sel_oe_r, req_oe_r, ack_oe_r, atn_oe_r,
  input wire [2:0] ctrl_oe_r,
  input wire [DB_W-1:0] db_out_r, db_oe_r,
  input wire dbp_out_r, dbp_oe_r, rst_oe_r
);
  reg [3:0] brst_r;
  always @(posedge mclk) brst_r <= {brst_r[2:0], bus_rst_pin};
  wire ok = rst_b && !bus_rst_pin && brst_r == 4'h0;
  wire arb = ok && phase == `PH_ARB;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_arb; arb && arbitrating; endsequence
  sequence s_arb_par; arb ##1 dbp_oe_r; endsequence
  // Synchronised bus reset is acting on the drivers
  sequence s_brst_seen;
    brst_r[1] && $past(rst_b) && $past(rst_b, 2);
  endsequence
  a_arb_own_bit: assert property (
    s_arb |=> db_oe_r == (8'h01 << $past(own_id)) && db_out_r == db_oe_r)
    else $error("arb data bit");
  a_par_choice: assert property (
    arb |=> dbp_oe_r == $past(arbitrating && arb_par_drive))
    else $error("arb parity oe");
  a_par_never_neg: assert property (
    s_arb_par |-> dbp_out_r)
    else $error("parity negated");
  a_arb_bsy_all: assert property (
    s_arb ##0 bsy_req |=> bsy_oe_r)
    else $error("arb bsy");
  a_win_sel: assert property (
    arb |=> sel_oe_r == $past(arbitrating && arb_won && sel_req))
    else $error("win sel");
  a_init_only: assert property (
    ok ##1 (ack_oe_r || atn_oe_r) |-> $past(act_init))
    else $error("init drive");
  a_targ_only: assert property (
    ok ##1 (req_oe_r || |ctrl_oe_r) |-> $past(act_targ))
    else $error("targ drive");
  a_free_none: assert property (
    ok && phase == `PH_FREE |=> !bsy_oe_r && !sel_oe_r &&
    db_oe_r == 8'h00 && !dbp_oe_r)
    else $error("free");
  a_joint_bsy: assert property (
    ok && phase == `PH_SEL && bsy_req && (act_init || act_targ)
    |=> bsy_oe_r)
    else $error("sel bsy");
  a_rst_any: assert property (
    ok && rst_req |=> rst_oe_r)
    else $error("bus reset");
  a_bus_rst_clear: assert property (
    s_brst_seen |=> !bsy_oe_r && !sel_oe_r && ctrl_oe_r == 3'h0 &&
    !req_oe_r && !ack_oe_r && !atn_oe_r && !dbp_oe_r &&
    db_oe_r == {DB_W{1'b0}})
    else $error("bus reset release");
endmodule // drv_own_assertions
bind drv_own drv_own_assertions #(.ID_W(ID_W), .DB_W(DB_W)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .arbitrating(arbitrating),
  .arb_won(arb_won), .act_init(act_init), .act_targ(act_targ),
  .bsy_req(bsy_req), .sel_req(sel_req), .arb_par_drive(arb_par_drive),
  .rst_req(rst_req), .bus_rst_pin(bus_rst_pin), .phase(phase),
  .own_id(own_id), .bsy_oe_r(bsy_oe_r), .sel_oe_r(sel_oe_r),
  .req_oe_r(req_oe_r), .ack_oe_r(ack_oe_r), .atn_oe_r(atn_oe_r),
  .ctrl_oe_r(ctrl_oe_r), .db_out_r(db_out_r), .db_oe_r(db_oe_r),
  .dbp_out_r(dbp_out_r), .dbp_oe_r(dbp_oe_r), .rst_oe_r(rst_oe_r));

// *** dv/rival_arb.sv ***
// Purpose: Second arbitrator on the shared data lines
// Assumes: Registered like the device, released as 0
// Notes:   Never drives parity negated
`timescale 1ns/1ps
module rival_arb (
  input  wire       mclk,
  input  wire       en,
  input  wire [2:0] id,
  output reg  [7:0] db_drv,
  output reg        par_drv
);
  always @(posedge mclk) begin
    db_drv  <= en ? 8'h01 << id : 8'h00;
    par_drv <= en;
  end
endmodule // rival_arb

// *** dv/tb_top.sv ***
// Purpose: Bench for bus driver ownership
// Assumes: Inputs change 1 ns after mclk rises
// Notes:   oe packs bsy,sel,ctrl,req,ack,atn
`timescale 1ns/1ps
`include "drv_own_consts.vh"
module tb_top;
  reg mclk = 0, rst_b = 0, brst = 0, apd = 1, rreq = 0, req = 1;
  reg [3:0] phase = 0, role = 0;
  wire [7:0] oe, dout, doe, oth;
  wire dpo, dpe, rst_oe, opar;
  integer err_count = 0, cmp_count = 0, i;
  initial forever #10 mclk = ~mclk;
  drv_own dut (.mclk(mclk), .rst_b(rst_b), .phase(phase), .own_id(3'h5),
    .arbitrating(role[3]), .arb_won(role[2]), .act_init(role[1]),
    .act_targ(role[0]), .bsy_req(req), .sel_req(req), .ctrl_req({3{req}}),
    .req_req(req), .ack_req(req), .atn_req(req), .db_req(req),
    .db_val(8'h3c), .dbp_val(req), .arb_par_drive(apd), .rst_req(rreq),
    .bus_rst_pin(brst), .bsy_oe_r(oe[7]), .sel_oe_r(oe[6]),
    .ctrl_oe_r(oe[5:3]), .req_oe_r(oe[2]), .ack_oe_r(oe[1]),
    .atn_oe_r(oe[0]), .db_out_r(dout), .db_oe_r(doe), .dbp_out_r(dpo),
    .dbp_oe_r(dpe), .rst_oe_r(rst_oe));
  rival_arb oth_i (.mclk(mclk), .en(phase == `PH_ARB), .id(3'h2),
    .db_drv(oth), .par_drv(opar));
  // ----------------------------------------------------------------
  // Compare and drive
  // ----------------------------------------------------------------
  task chk(input [7:0] g, input [7:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task go(input [3:0] p, input [3:0] r);
    phase = p;
    role = r;
    @(posedge mclk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_arb;
    go(`PH_ARB, 4'h8);
    chk(oe, 8'h80);
    chk((doe & dout) | oth, 8'h24);
    chk({6'h00, dpe, dpo}, 8'h03);
    chk({7'h00, dpe & ~dpo & opar}, 8'h00);
    go(`PH_ARB, 4'hc);
    chk(oe, 8'hc0);
    apd = 0;
    go(`PH_ARB, 4'hc);
    chk({6'h00, dpe, dpo}, 8'h01);
    apd = 1;
    go(`PH_ARB, 4'h0);
    chk(oe | doe, 8'h00);
  endtask
  task t_sel;
    go(`PH_SEL, 4'h2);
    chk(oe, 8'hc3);
    chk(doe & dout, 8'h3c);
    go(`PH_SEL, 4'h1);
    chk(oe, 8'h80);
    go(`PH_RESEL, 4'h1);
    chk(oe, 8'hfc);
    go(`PH_RESEL, 4'h2);
    chk(oe, 8'h83);
  endtask
  task t_info;
    for (i = 4; i < 10; i = i + 1) begin
      go(i[3:0], 4'h1);
      chk(oe, 8'hbc);
      chk(doe, (i == 5 || i == 7 || i == 8) ? 8'hff : 8'h00);
      go(i[3:0], 4'h2);
      chk(oe, 8'h03);
      chk(doe, (i == 5 || i == 7 || i == 8) ? 8'h00 : 8'hff);
    end
  endtask
  task t_none;
    go(`PH_FREE, 4'hf);
    chk(oe | doe, 8'h00);
    chk({7'h00, dpe}, 8'h00);
    req = 0;
    go(`PH_CMD, 4'h1);
    chk(oe, 8'h00);
    req = 1;
    rreq = 1;
    go(`PH_DIN, 4'h0);
    chk({7'h00, rst_oe}, 8'h01);
    chk(oe | doe, 8'h00);
    brst = 1;
    go(`PH_CMD, 4'h1);
    chk(oe, 8'hbc);
    repeat (3) @(posedge mclk);
    #1;
    chk(oe | doe, 8'h00);
    chk({7'h00, rst_oe}, 8'h01);
    brst = 0;
    rreq = 0;
  endtask
  // ----------------------------------------------------------------
  // Verdict and run
  // ----------------------------------------------------------------
  task end_sim;
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst_b = 1;
    chk(oe, 8'h00);
    t_arb;
    t_sel;
    t_info;
    t_none;
    end_sim;
  end
  initial begin
    #20000;
    err_count = err_count + 1;
    end_sim;
  end
endmodule // tb_top
